// ==== rtl/ccs_core.sv ====
// Purpose: APB-controlled executor for complement, compare-skip, clear ops
// Assumes: One Q phase per mclk cycle, four phases per instruction cycle
// Notes: Writing the instruction register starts one instruction
//
// The APB register port and the register addresses were chosen for this implementation.
module ccs_core (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             watchdogClear,
  output logic             fetchFlush,
  output logic             busy
);
  localparam int MEM_DEPTH = 4096;

  ccs_pkg::ccs_state_type state_reg;
  logic [1:0]  nopCnt_reg;
  logic [15:0] instr_reg;
  logic [7:0]  wReg_reg;
  logic [3:0]  bankSel_reg;
  logic [11:0] indexBase_reg;
  logic [11:0] memPtr_reg;
  logic        extEnable_reg;
  logic        zero_reg;
  logic        neg_reg;
  logic        timeout_reg;
  logic        powerdown_reg;
  logic        skip_reg;
  logic [7:0]  operand_reg;
  logic [11:0] opAddr_reg;
  logic [7:0]  result_reg;
  logic [7:0]  mem [0:MEM_DEPTH-1];
  logic [31:0] rdMux;
  logic        setupPhase;
  logic        commitWr;
  logic        mapped;
  logic        execMemWr;

  ccs_exec_if alu ();

  ccs_exec_unit u_exec (
    .bus (alu.unit)
  );

  assign alu.opcode    = instr_reg;
  assign alu.operand   = operand_reg;
  assign alu.wIn       = wReg_reg;
  assign alu.bankSel   = bankSel_reg;
  assign alu.indexBase = indexBase_reg;
  assign alu.extEnable = extEnable_reg;

  // APB decode
  assign setupPhase = psel && !penable;
  assign commitWr   = psel && penable && pready && pwrite && !pslverr;
  assign mapped     = paddr inside {ccs_pkg::OFF_CTRL, ccs_pkg::OFF_INSTR,
                                    ccs_pkg::OFF_WREG, ccs_pkg::OFF_BANK,
                                    ccs_pkg::OFF_STATUS, ccs_pkg::OFF_INDEX,
                                    ccs_pkg::OFF_MADDR, ccs_pkg::OFF_MDATA};

  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      ccs_pkg::OFF_CTRL:   rdMux[ccs_pkg::CTRL_EXT_BIT] = extEnable_reg;
      ccs_pkg::OFF_INSTR:  rdMux[15:0] = instr_reg;
      ccs_pkg::OFF_WREG:   rdMux[7:0] = wReg_reg;
      ccs_pkg::OFF_BANK:   rdMux[3:0] = bankSel_reg;
      ccs_pkg::OFF_STATUS: begin
        rdMux[ccs_pkg::ST_Z_BIT]    = zero_reg;
        rdMux[ccs_pkg::ST_N_BIT]    = neg_reg;
        rdMux[ccs_pkg::ST_PWRDN_BIT] = powerdown_reg;
        rdMux[ccs_pkg::ST_TMO_BIT]   = timeout_reg;
        rdMux[ccs_pkg::ST_BUSY_BIT] = busy;
        rdMux[ccs_pkg::ST_SKIP_BIT] = skip_reg;
      end
      ccs_pkg::OFF_INDEX:  rdMux[11:0] = indexBase_reg;
      ccs_pkg::OFF_MADDR:  rdMux[11:0] = memPtr_reg;
      ccs_pkg::OFF_MDATA:  rdMux[7:0] = mem[memPtr_reg];
      default:             rdMux = 32'h0000_0000;
    endcase
  end

  // APB answer, one access cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata  <= rdMux;
        pslverr <= !mapped || (pwrite && busy && paddr != ccs_pkg::OFF_CTRL);
      end
    end
  end

  // Software registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      extEnable_reg <= 1'b0;
      bankSel_reg   <= ccs_pkg::RST_BANK;
      indexBase_reg <= ccs_pkg::RST_INDEX;
      memPtr_reg    <= ccs_pkg::RST_MADDR;
      instr_reg     <= ccs_pkg::RST_INSTR;
    end else if (commitWr) begin
      case (paddr)
        ccs_pkg::OFF_CTRL:  extEnable_reg <= pwdata[ccs_pkg::CTRL_EXT_BIT];
        ccs_pkg::OFF_BANK:  bankSel_reg <= pwdata[3:0];
        ccs_pkg::OFF_INDEX: indexBase_reg <= pwdata[11:0];
        ccs_pkg::OFF_MADDR: memPtr_reg <= pwdata[11:0];
        ccs_pkg::OFF_INSTR: instr_reg <= pwdata[15:0];
        default:            memPtr_reg <= memPtr_reg;
      endcase
    end
  end

  // Instruction sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg  <= ccs_pkg::ST_IDLE;
      nopCnt_reg <= 2'h0;
      busy       <= 1'b0;
      fetchFlush <= 1'b0;
    end else begin
      fetchFlush <= 1'b0;
      case (state_reg)
        ccs_pkg::ST_IDLE: begin
          if (commitWr && paddr == ccs_pkg::OFF_INSTR) begin
            state_reg <= ccs_pkg::ST_Q1;
            busy      <= 1'b1;
          end
        end
        ccs_pkg::ST_Q1: state_reg <= ccs_pkg::ST_Q2;
        ccs_pkg::ST_Q2: state_reg <= ccs_pkg::ST_Q3;
        ccs_pkg::ST_Q3: state_reg <= ccs_pkg::ST_Q4;
        ccs_pkg::ST_Q4: begin
          if (alu.isCmpSkip && skip_reg) begin
            state_reg  <= ccs_pkg::ST_NOP;
            nopCnt_reg <= 2'h0;
            fetchFlush <= 1'b1;
          end else begin
            state_reg <= ccs_pkg::ST_IDLE;
            busy      <= 1'b0;
          end
        end
        ccs_pkg::ST_NOP: begin
          nopCnt_reg <= nopCnt_reg + 2'h1;
          if (nopCnt_reg == ccs_pkg::Q_LAST) begin
            state_reg <= ccs_pkg::ST_IDLE;
            busy      <= 1'b0;
          end
        end
        default: begin
          state_reg <= ccs_pkg::ST_IDLE;
          busy      <= 1'b0;
        end
      endcase
    end
  end

  // Q2 read, Q3 process
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      operand_reg <= 8'h00;
      result_reg  <= 8'h00;
      opAddr_reg  <= ccs_pkg::RST_MADDR;
    end else begin
      if (state_reg == ccs_pkg::ST_Q2) begin
        operand_reg <= mem[alu.memAddr];
        // Write-back address frozen at read time
        opAddr_reg  <= alu.memAddr;
      end
      if (state_reg == ccs_pkg::ST_Q3) begin
        result_reg <= alu.result;
      end
    end
  end

  // Status flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zero_reg      <= 1'b0;
      neg_reg       <= 1'b0;
      timeout_reg   <= ccs_pkg::RST_TMO;
      powerdown_reg <= ccs_pkg::RST_PWRDN;
      skip_reg      <= 1'b0;
      watchdogClear <= 1'b0;
    end else begin
      watchdogClear <= 1'b0;
      if (commitWr && paddr == ccs_pkg::OFF_STATUS) begin
        zero_reg      <= pwdata[ccs_pkg::ST_Z_BIT];
        neg_reg       <= pwdata[ccs_pkg::ST_N_BIT];
        powerdown_reg <= pwdata[ccs_pkg::ST_PWRDN_BIT];
        timeout_reg   <= pwdata[ccs_pkg::ST_TMO_BIT];
      end else if (state_reg == ccs_pkg::ST_Q3) begin
        if (alu.isCplFile) begin
          neg_reg  <= alu.negFlag;
          zero_reg <= alu.zeroFlag;
        end
        if (alu.isClrFile) begin
          zero_reg <= 1'b1;
        end
        if (alu.isClrWdog) begin
          watchdogClear <= 1'b1;
          timeout_reg   <= 1'b1;
          powerdown_reg <= 1'b1;
        end
        skip_reg <= alu.isCmpSkip && alu.equal;
      end
    end
  end

  assign execMemWr = state_reg == ccs_pkg::ST_Q4 &&
                     ((alu.isCplFile && !alu.toW) || alu.isClrFile);

  always_ff @(posedge mclk) begin
    if (execMemWr) begin
      mem[opAddr_reg] <= result_reg;
    end else if (commitWr && paddr == ccs_pkg::OFF_MDATA) begin
      mem[memPtr_reg] <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wReg_reg <= ccs_pkg::RST_WREG;
    end else if (state_reg == ccs_pkg::ST_Q4 && alu.isCplFile && alu.toW) begin
      wReg_reg <= result_reg;
    end else if (commitWr && paddr == ccs_pkg::OFF_WREG) begin
      wReg_reg <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_cpl_invert: assert property (
    (state_reg == ccs_pkg::ST_Q3 && alu.isCplFile) |=>
      result_reg == ~operand_reg && zero_reg == (result_reg == 8'h00) &&
      neg_reg == result_reg[7])
    else $error("complement result or flags wrong");
  a_cpl_to_w: assert property (
    (state_reg == ccs_pkg::ST_Q4 && alu.isCplFile && alu.toW) |->
      !execMemWr ##1 wReg_reg == $past(result_reg))
    else $error("complement to W failed");
  a_cpl_to_f: assert property (
    (state_reg == ccs_pkg::ST_Q4 && alu.isCplFile && !alu.toW) |->
      execMemWr && opAddr_reg == alu.memAddr ##1
      mem[$past(opAddr_reg)] == $past(result_reg))
    else $error("complement write back failed");
  a_access_bank: assert property (
    (busy && !instr_reg[ccs_pkg::OPC_A_BIT] && !extEnable_reg) |->
      alu.memAddr == {(instr_reg[7] ? ccs_pkg::ACC_HI_BANK : ccs_pkg::ACC_LO_BANK),
                      instr_reg[7:0]})
    else $error("access bank address wrong");
  a_bank_select: assert property (
    (busy && instr_reg[ccs_pkg::OPC_A_BIT]) |->
      alu.memAddr == {bankSel_reg, instr_reg[7:0]})
    else $error("bank select address wrong");
  a_indexed_mode: assert property (
    (busy && !instr_reg[ccs_pkg::OPC_A_BIT] && extEnable_reg &&
     instr_reg[7:0] <= ccs_pkg::LIT_LIMIT) |->
      alu.memAddr == indexBase_reg + {4'h0, instr_reg[7:0]})
    else $error("indexed address wrong");
  a_index_limit: assert property (
    (busy && !instr_reg[ccs_pkg::OPC_A_BIT] && extEnable_reg &&
     instr_reg[7:0] > ccs_pkg::LIT_LIMIT) |->
      alu.memAddr == {(instr_reg[7] ? ccs_pkg::ACC_HI_BANK : ccs_pkg::ACC_LO_BANK),
                      instr_reg[7:0]})
    else $error("indexed mode above limit");
  a_cmp_flags: assert property (
    (state_reg == ccs_pkg::ST_Q2 && alu.isCmpSkip) |=>
      ##1 $stable({zero_reg, neg_reg, timeout_reg, powerdown_reg}) [*3])
    else $error("compare changed a flag");
  a_cmp_equal: assert property (
    (state_reg == ccs_pkg::ST_Q3 && alu.isCmpSkip) |=>
      skip_reg == ($past(operand_reg) == $past(wReg_reg)))
    else $error("compare equality wrong");
  a_skip_nop: assert property (
    (state_reg == ccs_pkg::ST_Q4 && alu.isCmpSkip && skip_reg) |=>
      fetchFlush ##0 (state_reg == ccs_pkg::ST_NOP) [*4] ##1 !busy)
    else $error("skip did not run a no-op cycle");
  a_cmp_noskip: assert property (
    (state_reg == ccs_pkg::ST_Q4 && alu.isCmpSkip && !skip_reg) |=>
      !busy && !fetchFlush && state_reg == ccs_pkg::ST_IDLE)
    else $error("compare cycle count wrong");
  a_clear_zero: assert property (
    (state_reg == ccs_pkg::ST_Q1 && alu.isClrFile) |=> ##2
      (execMemWr && result_reg == 8'h00 && zero_reg) ##1 !busy)
    else $error("clear did not write zero");
  a_wdog_flags: assert property (
    (state_reg == ccs_pkg::ST_Q3 && alu.isClrWdog) |=>
      watchdogClear && timeout_reg && powerdown_reg ##1 !watchdogClear)
    else $error("watchdog clear wrong");

  c_skip: cover property (state_reg == ccs_pkg::ST_Q4 && alu.isCmpSkip && skip_reg);
  c_cpl_w: cover property (state_reg == ccs_pkg::ST_Q4 && alu.isCplFile && alu.toW);
  c_cpl_f: cover property (state_reg == ccs_pkg::ST_Q4 && alu.isCplFile && !alu.toW);
  c_wdog_clear: cover property (watchdogClear);
endmodule

// ==== rtl/ccs_pkg.sv ====
// Purpose: Shared constants and types for the compare/complement executor
// Assumes: 100 MHz mclk, one Q phase per mclk cycle
// Notes: Offsets are APB byte addresses
package ccs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int OP_W   = 16;

  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_INSTR  = 8'h04;
  localparam logic [7:0] OFF_WREG   = 8'h08;
  localparam logic [7:0] OFF_BANK   = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_INDEX  = 8'h14;
  localparam logic [7:0] OFF_MADDR  = 8'h18;
  localparam logic [7:0] OFF_MDATA  = 8'h1c;

  // Field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_Z_BIT     = 0;
  localparam int ST_N_BIT     = 1;
  localparam int ST_PWRDN_BIT = 2;
  localparam int ST_TMO_BIT   = 3;
  localparam int ST_BUSY_BIT  = 4;
  localparam int ST_SKIP_BIT  = 5;
  localparam int OPC_A_BIT    = 8;
  localparam int OPC_D_BIT    = 9;

  // Reset values
  localparam logic [7:0]  RST_WREG  = 8'h00;
  localparam logic [3:0]  RST_BANK  = 4'h0;
  localparam logic [11:0] RST_INDEX = 12'h000;
  localparam logic [11:0] RST_MADDR = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic        RST_TMO   = 1'b1;
  localparam logic        RST_PWRDN = 1'b1;

  // Opcode patterns
  localparam logic [5:0]  OPC_CPL_FILE = 6'h07;
  localparam logic [6:0]  OPC_CMP_SKIP = 7'h31;
  localparam logic [6:0]  OPC_CLR_FILE = 7'h35;
  localparam logic [15:0] OPC_CLR_WDOG = 16'h0004;

  // Addressing constants
  localparam logic [7:0] ACC_SPLIT   = 8'h80;
  localparam logic [7:0] LIT_LIMIT   = 8'h5f;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;

  // Timing: index of the last of the four Q phases per instruction cycle
  localparam logic [1:0] Q_LAST = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1   = 3'b001,
    ST_Q2   = 3'b010,
    ST_Q3   = 3'b011,
    ST_Q4   = 3'b100,
    ST_NOP  = 3'b101
  } ccs_state_type;
endpackage

// ==== rtl/ccs_exec_if.sv ====
// Purpose: Carrier between sequencer and decode/ALU unit
// Assumes: Purely combinational answer
// Notes: None
interface ccs_exec_if;
  logic [15:0] opcode;
  logic [7:0]  operand;
  logic [7:0]  wIn;
  logic [3:0]  bankSel;
  logic [11:0] indexBase;
  logic        extEnable;
  logic [11:0] memAddr;
  logic [7:0]  result;
  logic        isCplFile;
  logic        isCmpSkip;
  logic        isClrFile;
  logic        isClrWdog;
  logic        toW;
  logic        equal;
  logic        negFlag;
  logic        zeroFlag;

  modport core (output opcode, operand, wIn, bankSel, indexBase, extEnable,
                input memAddr, result, isCplFile, isCmpSkip, isClrFile, isClrWdog,
                input toW, equal, negFlag, zeroFlag);
  modport unit (input opcode, operand, wIn, bankSel, indexBase, extEnable,
                output memAddr, result, isCplFile, isCmpSkip, isClrFile, isClrWdog,
                output toW, equal, negFlag, zeroFlag);
endinterface

// ==== rtl/ccs_exec_unit.sv ====
// Purpose: Decode, operand address and result of one instruction
// Assumes: Opcode held stable for the whole instruction
// Notes: Combinational only
module ccs_exec_unit (
  ccs_exec_if.unit bus
);
  logic [7:0] fld;
  logic [8:0] diff;

  assign fld          = bus.opcode[7:0];
  assign bus.isCplFile = bus.opcode[15:10] == ccs_pkg::OPC_CPL_FILE;
  assign bus.isCmpSkip = bus.opcode[15:9] == ccs_pkg::OPC_CMP_SKIP;
  assign bus.isClrFile = bus.opcode[15:9] == ccs_pkg::OPC_CLR_FILE;
  assign bus.isClrWdog = bus.opcode == ccs_pkg::OPC_CLR_WDOG;
  assign bus.toW      = !bus.opcode[ccs_pkg::OPC_D_BIT];

  assign diff      = {1'b0, bus.operand} - {1'b0, bus.wIn};
  assign bus.equal = diff[7:0] == 8'h00;

  always_comb begin
    if (bus.opcode[ccs_pkg::OPC_A_BIT]) begin
      bus.memAddr = {bus.bankSel, fld};
    end else if (bus.extEnable && fld <= ccs_pkg::LIT_LIMIT) begin
      bus.memAddr = bus.indexBase + {4'h0, fld};
    end else if (fld < ccs_pkg::ACC_SPLIT) begin
      bus.memAddr = {ccs_pkg::ACC_LO_BANK, fld};
    end else begin
      bus.memAddr = {ccs_pkg::ACC_HI_BANK, fld};
    end
  end

  always_comb begin
    if (bus.isCplFile) begin
      bus.result = ~bus.operand;
    end else if (bus.isClrFile) begin
      bus.result = 8'h00;
    end else begin
      bus.result = bus.operand;
    end
  end

  assign bus.negFlag  = bus.result[7];
  assign bus.zeroFlag = bus.result == 8'h00;
endmodule

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the complement/compare-skip/clear executor
// Assumes: Zero-wait APB slave, one Q phase per mclk cycle
// Notes: Random operands from an xorshift source; model tracks one memory byte per op
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        watchdogClear;
  logic        fetchFlush;
  logic        busy;
  int          failures;
  int          checks_done;
  int          flushCnt;
  int          wdCnt;
  int          busyCnt;
  logic [31:0] seed;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  offs [7];
  logic [31:0] rstExp [7];

  ccs_core u_dut (
    .mclk          (mclk),
    .rst           (rst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .watchdogClear (watchdogClear),
    .fetchFlush    (fetchFlush),
    .busy          (busy)
  );

  always #5 mclk = ~mclk;

  // Pulse and busy-cycle counters
  always @(posedge mclk) begin
    if (fetchFlush === 1'b1) flushCnt <= flushCnt + 1;
    if (watchdogClear === 1'b1) wdCnt <= wdCnt + 1;
    if (busy === 1'b1) busyCnt <= busyCnt + 1;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] data, output logic resp);
    int j;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    j = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && j < 50) begin
      @(posedge mclk);
      j++;
    end
    chk_resp("pready", 1'b1, pready);
    data = prdata;
    resp = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_data(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_resp(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] tmp;
    logic        e;
    apb(1'b1, a, d, tmp, e);
    chk_resp("write response", 1'b0, e);
  endtask

  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rd, err);
  endtask

  task automatic results();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic run_op(input int kind);
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] exSt;
    logic [7:0]  f;
    logic [7:0]  w;
    logic [7:0]  mv;
    logic [7:0]  res;
    logic [7:0]  exMem;
    logic [7:0]  exW;
    logic [3:0]  bank;
    logic [3:0]  sn;
    logic [11:0] idx;
    logic [11:0] addr;
    logic [15:0] op;
    logic        a;
    logic        d;
    logic        ext;
    logic        eq;
    logic        zFlag;
    logic        nFlag;
    logic        pwrdnFlag;
    logic        tmoFlag;
    int          exBusy;
    int          j;
    r1 = rnd();
    r2 = rnd();
    f = r1[7:0];
    w = r1[15:8];
    a = r1[16];
    d = r1[17];
    ext = r1[18];
    bank = r1[22:19];
    sn = r1[26:23];
    idx = r2[11:0];
    mv = r2[12] ? w : r2[20:13];
    if (a)
      addr = {bank, f};
    else if (ext && f <= ccs_pkg::LIT_LIMIT)
      addr = idx + {4'h0, f};
    else if (f < ccs_pkg::ACC_SPLIT)
      addr = {ccs_pkg::ACC_LO_BANK, f};
    else
      addr = {ccs_pkg::ACC_HI_BANK, f};
    wr(ccs_pkg::OFF_CTRL, {31'h0, ext});
    wr(ccs_pkg::OFF_BANK, {28'h0, bank});
    wr(ccs_pkg::OFF_INDEX, {20'h0, idx});
    wr(ccs_pkg::OFF_WREG, {24'h0, w});
    wr(ccs_pkg::OFF_MADDR, {20'h0, addr});
    wr(ccs_pkg::OFF_MDATA, {24'h0, mv});
    wr(ccs_pkg::OFF_STATUS, {28'h0, sn});
    {tmoFlag, pwrdnFlag, nFlag, zFlag} = sn;
    exW = w;
    exMem = mv;
    eq = 1'b0;
    exBusy = 4;
    case (kind)
      0: begin
        op = {ccs_pkg::OPC_CPL_FILE, d, a, f};
        res = ~mv;
        if (d) exMem = res;
        else exW = res;
        zFlag = (res == 8'h00);
        nFlag = res[7];
      end
      1: begin
        op = {ccs_pkg::OPC_CMP_SKIP, a, f};
        eq = (mv == w);
        if (eq) exBusy = 8;
      end
      2: begin
        op = {ccs_pkg::OPC_CLR_FILE, a, f};
        exMem = 8'h00;
        zFlag = 1'b1;
      end
      default: begin
        op = ccs_pkg::OPC_CLR_WDOG;
        tmoFlag = 1'b1;
        pwrdnFlag = 1'b1;
      end
    endcase
    flushCnt = 0;
    wdCnt = 0;
    busyCnt = 0;
    wr(ccs_pkg::OFF_INSTR, {16'h0, op});
    apb(1'b1, ccs_pkg::OFF_WREG, {24'h0, ~w}, rd, err);
    chk_resp("write while busy", 1'b1, err);
    j = 0;
    while (busy !== 1'b0 && j < 100) begin
      @(posedge mclk);
      j++;
    end
    chk_resp("busy done", 1'b0, busy);
    exSt = {26'h0, eq, 1'b0, tmoFlag, pwrdnFlag, nFlag, zFlag};
    rdreg(ccs_pkg::OFF_WREG);
    chk_data("working reg", {24'h0, exW}, rd);
    rdreg(ccs_pkg::OFF_MDATA);
    chk_data("memory byte", {24'h0, exMem}, rd);
    rdreg(ccs_pkg::OFF_STATUS);
    chk_data("status", exSt, rd);
    chk_data("busy cycles", 32'(exBusy), 32'(busyCnt));
    chk_data("flush pulses", {31'h0, eq}, 32'(flushCnt));
    chk_data("watchdog pulses", {31'h0, kind == 3}, 32'(wdCnt));
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h1166;
    failures = 0;
    checks_done = 0;
    offs = '{ccs_pkg::OFF_CTRL, ccs_pkg::OFF_INSTR, ccs_pkg::OFF_WREG, ccs_pkg::OFF_BANK,
             ccs_pkg::OFF_STATUS, ccs_pkg::OFF_INDEX, ccs_pkg::OFF_MADDR};
    rstExp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0c, 32'h0, 32'h0};
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rdreg(offs[i]);
      chk_data("reset value", rstExp[i], rd);
    end
    rdreg(8'h20);
    chk_resp("unmapped response", 1'b1, err);
    chk_data("unmapped read", 32'h0, rd);
    for (int i = 0; i < 120; i++) run_op(i % 4);
    results();
  end

  // Hang guard
  initial begin
    #800000;
    failures++;
    results();
  end
endmodule
